// [logic/mcm_top.sv]
/*
 * Modem connection manager: carries out dial, hang-up, string install,
 * password and modem configuration requests, drives DTR and watches DCD.
 * Assumes requests arrive over APB and modem bytes leave on a ready/valid
 * byte port towards a UART.
 */
`timescale 1ns/1ps
`default_nettype none
module mcm_top #(
	parameter longint DTR_CYC = mcm_pkg::DTR_LOW_CYC,
	parameter longint MIN_CYC = mcm_pkg::MINUTE_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        dcd,
	input  wire logic        link_activity,
	input  wire logic        host_cmd_valid,
	input  wire logic [7:0]  host_cmd_code,
	output logic             host_cmd_reject,
	output logic             dtr,
	input  wire logic        tx_ready,
	output logic      [7:0]  tx_data,
	output logic             tx_valid
);
	logic [7:0]  store [mcm_pkg::STR_NUM][mcm_pkg::STR_LEN];
	logic [31:0] req0_r, req1_r;
	logic        mip_mode_r, modem_en_r, from_host_r, go_r;
	logic        resp_valid_r, resp_ok_r, authed_r;
	logic [1:0]  conn_r;
	logic [7:0]  hang_min_r, free_r;
	logic [7:0]  slot_len [mcm_pkg::STR_NUM];
	mcm_pkg::mcm_state_t st_r;
	logic [3:0]  step_r, str_sel_r;
	logic [39:0] cnt_r;
	logic [7:0]  min_cnt_r;
	logic        tx_start_r, tx_busy, tx_v;
	logic [7:0]  tx_d;
	logic [3:0]  tx_idx;
	logic        acc, wr, host_locked;
	logic [7:0]  cmd, arg0, arg1, arg2;
	logic [3:0]  dir_max;

	assign acc  = psel && penable;
	assign wr   = acc && pwrite;
	assign cmd  = req0_r[15:8];
	assign arg0 = req0_r[23:16];
	assign arg1 = req0_r[31:24];
	assign arg2 = req1_r[7:0];
	assign dir_max = mip_mode_r ? 4'(mcm_pkg::MIP_DIR_MAX) : 4'(mcm_pkg::NSI_DIR_MAX);
	assign host_locked = modem_en_r && slot_len[mcm_pkg::STR_PWD] != 8'h00 && !authed_r;

	////////////////////////////////////////////////////////////////////
	// APB slave: single-cycle access, unmapped reads zero, no error
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			case (paddr)
			mcm_pkg::REG_REQ0: prdata <= req0_r;
			mcm_pkg::REG_REQ1: prdata <= req1_r;
			mcm_pkg::REG_CTRL: prdata <= {28'h0, from_host_r, modem_en_r, mip_mode_r, 1'b0};
			mcm_pkg::REG_STAT: prdata <= {8'h0, hang_min_r, free_r, 2'h0, authed_r, tx_busy,
			                              resp_ok_r, resp_valid_r, conn_r};
			default:           prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Request words and control bits
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			req0_r      <= 32'h0000_0000;
			req1_r      <= 32'h0000_0000;
			mip_mode_r  <= 1'b1;
			modem_en_r  <= 1'b1;
			from_host_r <= 1'b0;
			go_r        <= 1'b0;
		end else begin
			// A start waits here until the sequencer is idle to take it
			if (st_r == mcm_pkg::MCM_IDLE)
				go_r <= 1'b0;
			if (wr && pready && paddr == mcm_pkg::REG_REQ0)
				req0_r <= pwdata;
			if (wr && pready && paddr == mcm_pkg::REG_REQ1)
				req1_r <= pwdata;
			if (wr && pready && paddr == mcm_pkg::REG_CTRL) begin
				go_r        <= pwdata[0] || (go_r && st_r != mcm_pkg::MCM_IDLE);
				mip_mode_r  <= pwdata[1];
				modem_en_r  <= pwdata[2];
				from_host_r <= pwdata[3];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// String store with defaults; install writes one byte per request
	// Left-justified so that byte 0 is the first character, nulls after
	localparam logic [8*16-1:0] DEF_CFG = {"ATE0&C1&D2S0=1!", 8'h00};
	localparam logic [8*16-1:0] DEF_HUP = {"~~~+++~~~ATH0!", 16'h0000};
	localparam logic [8*16-1:0] DEF_PRE = {"ATDT", 96'h0};
	logic inst_ok;
	logic [3:0] inst_slot;
	always_comb begin
		inst_slot = (cmd == mcm_pkg::CMD_INST_CFG) ? mcm_pkg::STR_CFG :
		            (cmd == mcm_pkg::CMD_INST_HUP) ? mcm_pkg::STR_HUP :
		            (cmd == mcm_pkg::CMD_INST_PRE) ? mcm_pkg::STR_PRE : mcm_pkg::STR_PWD;
		inst_ok = arg0 <= free_r + slot_len[inst_slot] && arg0 <= 8'(mcm_pkg::STR_LEN)
		          && arg1 < 8'(mcm_pkg::STR_LEN);
	end

	genvar gs, gb;
	generate
		for (gs = 0; gs < mcm_pkg::STR_NUM; gs++) begin : g_slot
			for (gb = 0; gb < mcm_pkg::STR_LEN; gb++) begin : g_byte
				always_ff @(posedge clk or posedge sys_rst) begin
					if (sys_rst) begin
						// Defaults loaded at reset
						if (gs == mcm_pkg::STR_CFG)
							store[gs][gb] <= DEF_CFG[8*(15-gb) +: 8];
						else if (gs == mcm_pkg::STR_HUP)
							store[gs][gb] <= DEF_HUP[8*(15-gb) +: 8];
						else if (gs == mcm_pkg::STR_PRE)
							store[gs][gb] <= DEF_PRE[8*(15-gb) +: 8];
						else
							store[gs][gb] <= 8'h00;
					end else if (st_r == mcm_pkg::MCM_DECODE && step_r == 4'h1 && inst_ok
					             && inst_slot == 4'(gs) && arg1 == 8'(gb))
						store[gs][gb] <= arg2;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Command sequencer
	logic        dcd_seen;
	logic        entry_ok, pwd_ok;
	always_comb begin
		entry_ok = arg1[3:0] <= dir_max && arg1[7:4] == 4'h0 && store[arg1[2:0]][0] != 8'h00;
		pwd_ok   = 1'b1;
		for (int i = 0; i < mcm_pkg::PWD_MAX; i++)
			if (req1_r[8*(i%4) +: 8] != store[mcm_pkg::STR_PWD][i] && i < 4)
				pwd_ok = 1'b0;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r         <= mcm_pkg::MCM_SEND; // configure modem at reset
			step_r       <= 4'hF; // Silent: no request to answer
			str_sel_r    <= mcm_pkg::STR_CFG;
			tx_start_r   <= 1'b1;
			conn_r       <= mcm_pkg::CONN_IDLE;
			resp_valid_r <= 1'b0;
			resp_ok_r    <= 1'b0;
			authed_r     <= 1'b0;
			dtr          <= 1'b1;
			cnt_r        <= 40'h0;
			dcd_seen     <= 1'b1; // Reset string counts as sent
			hang_min_r   <= 8'h00;
			min_cnt_r    <= 8'h00;
			free_r       <= mcm_pkg::POOL_BYTES;
			for (int s = 0; s < mcm_pkg::STR_NUM; s++)
				slot_len[s] <= (s == mcm_pkg::STR_CFG) ? 8'h10 : (s == mcm_pkg::STR_HUP) ? 8'h0F :
				               (s == mcm_pkg::STR_PRE) ? 8'h05 : 8'h00;
		end else begin
			tx_start_r <= 1'b0;
			// Track carrier: connect and drop update the reported state;
			// no new call is seen while a hang-up is still running
			if (conn_r == mcm_pkg::CONN_DIALING && dcd)
				conn_r <= mcm_pkg::CONN_UP;
			if (conn_r == mcm_pkg::CONN_IDLE && dcd && st_r == mcm_pkg::MCM_IDLE) begin
				conn_r   <= mcm_pkg::CONN_UP;
				authed_r <= 1'b0;
			end
			if (conn_r == mcm_pkg::CONN_UP && !dcd)
				conn_r <= mcm_pkg::CONN_IDLE; // Carrier lost
			// Idle hang-up timer
			if (conn_r != mcm_pkg::CONN_UP || link_activity || hang_min_r == 8'h00) begin
				cnt_r     <= (st_r == mcm_pkg::MCM_DTRLOW) ? cnt_r : 40'h0;
				min_cnt_r <= 8'h00;
			end else if (st_r == mcm_pkg::MCM_IDLE && cnt_r == 40'(MIN_CYC - 1)) begin
				cnt_r     <= 40'h0;
				min_cnt_r <= min_cnt_r + 8'h1;
			end else if (st_r == mcm_pkg::MCM_IDLE)
				cnt_r <= cnt_r + 40'h1;
			// Hide the previous answer while a new request waits
			if (go_r)
				resp_valid_r <= 1'b0;
			case (st_r)
			mcm_pkg::MCM_IDLE: begin
				if (go_r) begin
					st_r         <= mcm_pkg::MCM_DECODE;
					step_r       <= 4'h0;
					resp_valid_r <= 1'b0;
				end else if (hang_min_r != 8'h00 && min_cnt_r == hang_min_r) begin
					st_r   <= mcm_pkg::MCM_DTRLOW;
					dtr    <= 1'b0;
					cnt_r  <= 40'h0;
					step_r <= 4'h4; // silent hang-up, no answer
				end else if (conn_r != mcm_pkg::CONN_UP && conn_r != mcm_pkg::CONN_DIALING && !dcd_seen) begin
					str_sel_r  <= mcm_pkg::STR_CFG;
					tx_start_r <= 1'b1;
					st_r       <= mcm_pkg::MCM_SEND;
					step_r     <= 4'hF;
					dcd_seen   <= 1'b1;
				end
				if (conn_r == mcm_pkg::CONN_UP)
					dcd_seen <= 1'b0;
			end
			mcm_pkg::MCM_DECODE: begin
				st_r <= mcm_pkg::MCM_DONE;
				resp_ok_r <= 1'b1;
				if (req0_r[7:0] != mcm_pkg::SUB_CODE)
					resp_ok_r <= 1'b0;
				else case (cmd)
				mcm_pkg::CMD_DIAL_DIR: begin
					if (!entry_ok || (arg0 != mcm_pkg::MODE_DIAL && arg0 != mcm_pkg::MODE_HUP_DIAL))
						resp_ok_r <= 1'b0;
					else if (conn_r == mcm_pkg::CONN_UP && arg0 == mcm_pkg::MODE_DIAL)
						resp_ok_r <= 1'b1;
					else if (conn_r == mcm_pkg::CONN_UP) begin
						st_r <= mcm_pkg::MCM_DTRLOW;
						dtr  <= 1'b0;
						cnt_r <= 40'h0;
						step_r <= 4'h8;
					end else begin
						str_sel_r  <= mcm_pkg::STR_PRE;
						tx_start_r <= 1'b1;
						st_r       <= mcm_pkg::MCM_SEND;
						step_r     <= 4'h2;
					end
				end
				mcm_pkg::CMD_HANGUP: begin
					st_r   <= mcm_pkg::MCM_DTRLOW;
					dtr    <= 1'b0;
					cnt_r  <= 40'h0;
					step_r <= (arg0 != 8'h00) ? 4'h5 : 4'h6; // 4 is the silent timer case
				end
				mcm_pkg::CMD_INST_CFG, mcm_pkg::CMD_INST_HUP, mcm_pkg::CMD_INST_PRE,
				mcm_pkg::CMD_PASSWORD: begin
					if (!inst_ok || (cmd == mcm_pkg::CMD_INST_HUP && !mip_mode_r)
					    || (cmd == mcm_pkg::CMD_PASSWORD && (arg0 > 8'(mcm_pkg::PWD_MAX + 1)
					    || (from_host_r && host_locked))))
						resp_ok_r <= 1'b0;
					else begin
						st_r   <= mcm_pkg::MCM_DECODE;
						step_r <= 4'h1;
						free_r <= free_r + slot_len[inst_slot] - arg0;
						slot_len[inst_slot] <= (arg0 <= 8'h01) ? 8'h00 : arg0;
						if (step_r == 4'h1)
							st_r <= mcm_pkg::MCM_DONE;
					end
				end
				mcm_pkg::CMD_HANG_TMR: hang_min_r <= arg0;
				mcm_pkg::CMD_CFG_MODEM: begin
					if (conn_r == mcm_pkg::CONN_UP)
						resp_ok_r <= 1'b0;
					else begin
						str_sel_r  <= mcm_pkg::STR_CFG;
						tx_start_r <= 1'b1;
						st_r       <= mcm_pkg::MCM_SEND;
						step_r     <= 4'h0;
					end
				end
				default: resp_ok_r <= 1'b0;
				endcase
			end
			mcm_pkg::MCM_DTRLOW: begin
				cnt_r <= cnt_r + 40'h1;
				if (cnt_r == 40'(DTR_CYC - 1)) begin
					dtr <= 1'b1;
					if (dcd) begin
						if (slot_len[mcm_pkg::STR_HUP] == 8'h00)
							resp_ok_r <= 1'b0;
						else begin
							str_sel_r  <= mcm_pkg::STR_HUP;
							tx_start_r <= 1'b1;
						end
					end
					conn_r <= mcm_pkg::CONN_IDLE;
					st_r   <= mcm_pkg::MCM_SEND;
				end
			end
			mcm_pkg::MCM_SEND: begin
				if (!tx_busy && !tx_start_r) begin
					st_r <= mcm_pkg::MCM_DONE;
					if (step_r == 4'h2) begin
						str_sel_r  <= {1'b0, arg1[2:0]}; // entry after prefix
						tx_start_r <= 1'b1;
						st_r       <= mcm_pkg::MCM_SEND;
						step_r     <= 4'h3;
					end else if (step_r == 4'h3)
						conn_r <= mcm_pkg::CONN_DIALING;
					else if (step_r == 4'h5) begin
						str_sel_r  <= mcm_pkg::STR_CFG;
						tx_start_r <= 1'b1;
						st_r       <= mcm_pkg::MCM_SEND;
						step_r     <= 4'h0;
					end else if (step_r == 4'h8) begin
						str_sel_r  <= mcm_pkg::STR_PRE;
						tx_start_r <= 1'b1;
						st_r       <= mcm_pkg::MCM_SEND;
						step_r     <= 4'h2;
					end else if (step_r == 4'h4 || step_r == 4'hF)
						st_r <= mcm_pkg::MCM_WAIT;
				end
			end
			mcm_pkg::MCM_DONE: begin
				resp_valid_r <= 1'b1;
				st_r <= mcm_pkg::MCM_IDLE;
			end
			mcm_pkg::MCM_WAIT: begin
				resp_valid_r <= step_r == 4'h4 ? resp_valid_r : resp_valid_r;
				st_r <= mcm_pkg::MCM_IDLE;
			end
			default: st_r <= mcm_pkg::MCM_IDLE;
			endcase
			// Password gate for host commands
			if (host_cmd_valid && host_cmd_code == mcm_pkg::PASSWORD_CMD && pwd_ok)
				authed_r <= 1'b1;
		end
	end

	// Host command filter while locked
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			host_cmd_reject <= 1'b0;
		else
			host_cmd_reject <= host_cmd_valid && host_locked && conn_r == mcm_pkg::CONN_UP
			                   && host_cmd_code != mcm_pkg::PASSWORD_CMD;
	end

	////////////////////////////////////////////////////////////////////
	// Modem byte sender
	mcm_string_tx u_tx (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.start      (tx_start_r),
		.bang_to_cr (mip_mode_r),
		.cur_byte   (store[str_sel_r][tx_idx]),
		.byte_idx   (tx_idx),
		.tx_ready   (tx_ready),
		.tx_data    (tx_d),
		.tx_valid   (tx_v),
		.busy       (tx_busy)
	);
	assign tx_data  = tx_d;
	assign tx_valid = tx_v;
endmodule
`default_nettype wire

// [logic/mcm_pkg.sv]
/*
 * Package for the modem connection manager: request codes, connection
 * states, string identifiers, timing constants and the APB register map.
 * Assumes a 200 MHz system clock.
 */
package mcm_pkg;
	// Request framing
	localparam logic [7:0] SUB_CODE      = 8'h01;
	localparam logic [7:0] CMD_DIAL_DIR  = 8'h07;
	localparam logic [7:0] CMD_HANGUP    = 8'h08;
	localparam logic [7:0] CMD_PASSWORD  = 8'h09;
	localparam logic [7:0] CMD_INST_CFG  = 8'h0A;
	localparam logic [7:0] CMD_INST_HUP  = 8'h0B;
	localparam logic [7:0] CMD_INST_PRE  = 8'h0C;
	localparam logic [7:0] CMD_HANG_TMR  = 8'h0D;
	localparam logic [7:0] CMD_CFG_MODEM = 8'h0E;
	localparam logic [7:0] PASSWORD_CMD  = 8'hE4;
	localparam logic [7:0] MODE_DIAL     = 8'h01;
	localparam logic [7:0] MODE_HUP_DIAL = 8'h02;
	localparam logic [7:0] CHAR_BANG     = 8'h21;
	localparam logic [7:0] CHAR_CR       = 8'h0D;

	// Connection states as reported
	localparam logic [1:0] CONN_IDLE    = 2'h0;
	localparam logic [1:0] CONN_FAILED  = 2'h1;
	localparam logic [1:0] CONN_DIALING = 2'h2;
	localparam logic [1:0] CONN_UP      = 2'h3;

	// String store: 16 strings of 16 bytes (0..7 directory, then others)
	localparam int         STR_LEN     = 16;
	localparam int         STR_NUM     = 16;
	localparam logic [3:0] STR_CFG     = 4'h8;
	localparam logic [3:0] STR_HUP     = 4'h9;
	localparam logic [3:0] STR_PRE     = 4'hA;
	localparam logic [3:0] STR_PWD     = 4'hB;
	localparam logic [7:0] POOL_BYTES  = 8'hC0;
	localparam int         MIP_DIR_MAX = 7;
	localparam int         NSI_DIR_MAX = 4;
	localparam int         PWD_MAX     = 8;

	// Timing
	localparam int          CLK_MHZ       = 200;
	localparam int          DTR_LOW_MS    = 500;
	localparam longint      DTR_LOW_CYC   = longint'(DTR_LOW_MS) * 1000 * CLK_MHZ;
	localparam longint      MINUTE_CYC    = 64'd60_000 * 1000 * CLK_MHZ;

	// APB register byte offsets
	localparam logic [7:0] REG_REQ0   = 8'h00;
	localparam logic [7:0] REG_REQ1   = 8'h04;
	localparam logic [7:0] REG_CTRL   = 8'h08;
	localparam logic [7:0] REG_STAT   = 8'h0C;
	localparam logic [7:0] REG_RXCHAR = 8'h10;

	// Execution states, Gray in the order listed
	typedef enum logic [3:0] {
		MCM_IDLE   = 4'b0000,
		MCM_DECODE = 4'b0001,
		MCM_DTRLOW = 4'b0011,
		MCM_SEND   = 4'b0010,
		MCM_DONE   = 4'b0110,
		MCM_WAIT   = 4'b0111
	} mcm_state_t;
endpackage

// [logic/mcm_string_tx.sv]
/*
 * String sender: streams one stored string, byte by byte, to the modem
 * transmit port, stopping at the null byte or the end of the slot.
 * Assumes the modem port accepts a byte when tx_ready is high.
 */
`timescale 1ns/1ps
`default_nettype none
module mcm_string_tx (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        start,
	input  wire logic        bang_to_cr,
	input  wire logic [7:0]  cur_byte,
	output logic      [3:0]  byte_idx,
	input  wire logic        tx_ready,
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	output logic             busy
);
	logic active_r;
	logic last_r;

	////////////////////////////////////////////////////////////////////
	// Walk the string while the modem takes bytes; byte_idx always points
	// at the next byte to load, so no byte goes out twice
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			active_r <= 1'b0;
			last_r   <= 1'b0;
			byte_idx <= 4'h0;
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
		end else if (start) begin
			active_r <= 1'b1;
			last_r   <= 1'b0;
			byte_idx <= 4'h0;
			tx_valid <= 1'b0;
		end else if (active_r && (!tx_valid || tx_ready)) begin
			if (cur_byte == 8'h00 || last_r) begin
				active_r <= 1'b0;
				tx_valid <= 1'b0;
			end else begin
				tx_valid <= 1'b1;
				// Bang becomes carriage return
				tx_data  <= (bang_to_cr && cur_byte == mcm_pkg::CHAR_BANG) ? mcm_pkg::CHAR_CR : cur_byte;
				byte_idx <= byte_idx + 4'h1;
				last_r   <= (byte_idx == 4'hF); // Slot end reached
			end
		end
	end
	assign busy = active_r || start;
endmodule
`default_nettype wire

// [sim/mcm_monitor.sv]
/*
 * Port checker for the modem connection manager.
 * Assumes message-processor mode stays selected for the whole run.
 */
`timescale 1ns/1ps
`default_nettype none
module mcm_monitor #(
	parameter longint DTR_CYC = 20
) (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        dcd,
	input wire logic        link_activity,
	input wire logic        host_cmd_valid,
	input wire logic [7:0]  host_cmd_code,
	input wire logic        host_cmd_reject,
	input wire logic        dtr,
	input wire logic        tx_ready,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_valid
);
	logic [31:0] low_cnt;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////
	// Length of the current DTR pulse in cycles
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_cnt <= 32'h0;
		end else if (!dtr) begin
			low_cnt <= low_cnt + 32'h1;
		end else begin
			low_cnt <= 32'h0;
		end
	end

	////////////////////////////////////////////////////////////
	// Bus handshake
	a_pready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
	a_pready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	a_slverr_low: assert property (pready |-> !pslverr) else $error("error response given");
	// DTR pulse, modem byte stream and host command reject
	a_dtr_width: assert property ($rose(dtr) |-> low_cnt == DTR_CYC) else $error("DTR pulse length wrong");
	a_dtr_bound: assert property (!dtr |-> low_cnt < DTR_CYC) else $error("DTR low too long");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("tx byte dropped");
	a_no_bang: assert property (tx_valid |-> tx_data != mcm_pkg::CHAR_BANG) else $error("bang sent raw");
	a_quiet_pulse: assert property (!dtr |-> !tx_valid) else $error("byte sent during DTR pulse");
	a_reject_cause: assert property (host_cmd_reject |-> $past(host_cmd_valid)
		&& $past(host_cmd_code) != mcm_pkg::PASSWORD_CMD) else $error("reject without cause");
endmodule
`default_nettype wire

// [sim/mcm_modem_model.sv]
/*
 * Behavioural modem: takes bytes, counts them, holds carrier while the line is up and the call is not hung up.
 * Assumes the bench raises line_up to place a call and stubborn to ignore DTR.
 */
`timescale 1ns/1ps
`default_nettype none
module mcm_modem_model (
	input  wire logic       clk,
	input  wire logic       slow,
	input  wire logic       line_up,
	input  wire logic       stubborn,
	input  wire logic       dtr,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	output logic            dcd,
	output int              byte_cnt,
	output int              bang_cnt,
	output logic [7:0]      last_byte
);
	logic       hung;
	logic       cmd_mode;
	logic [1:0] plus_run;

	initial begin
		tx_ready = 1'b1; dcd = 1'b0; hung = 1'b0; cmd_mode = 1'b0;
		plus_run = 2'h0; byte_cnt = 0; bang_cnt = 0; last_byte = 8'h00;
	end

	////////////////////////////////////////////////////////////
	// Takes bytes, stalling every other cycle when slow
	always @(posedge clk) begin
		tx_ready <= slow ? !tx_ready : 1'b1;
		if (tx_valid && tx_ready) begin
			byte_cnt <= byte_cnt + 1;
			last_byte <= tx_data;
			bang_cnt <= bang_cnt + int'(tx_data == 8'h21);
			plus_run <= (tx_data == 8'h2B) ? plus_run + 2'h1 : 2'h0;
			if (plus_run == 2'h2 && tx_data == 8'h2B) begin
				cmd_mode <= 1'b1;
			end
			if (cmd_mode && tx_data == 8'h48) begin
				hung <= 1'b1;
			end
		end
		// Drops the call on a DTR pulse unless stubborn
		if (!dtr && !stubborn) begin
			hung <= 1'b1;
		end
		if (!line_up) begin
			hung <= 1'b0;
			cmd_mode <= 1'b0;
		end
		dcd <= line_up && !hung;
	end
endmodule
`default_nettype wire

// [sim/mcm_top_tb.sv]
/*
 * Bench for the modem connection manager: APB requests with expected results.
 * Assumes the short DTR and minute counts set below.
 */
`timescale 1ns/1ps
`default_nettype none
module mcm_top_tb;
	localparam longint DTR_CYC = 20;
	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, dcd, link_activity;
	logic        host_cmd_valid, host_cmd_reject, dtr, tx_ready, tx_valid;
	logic        slow, line_up, stubborn;
	logic [7:0]  paddr, host_cmd_code, tx_data, last_byte;
	logic [31:0] pwdata, prdata, st;
	int          error_cnt, checks_done, byte_cnt, bang_cnt, n0, cyc;

	mcm_top #(.DTR_CYC(DTR_CYC), .MIN_CYC(50)) mcm_top_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dcd(dcd), .link_activity(link_activity), .host_cmd_valid(host_cmd_valid),
		.host_cmd_code(host_cmd_code), .host_cmd_reject(host_cmd_reject), .dtr(dtr), .tx_ready(tx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid));
	mcm_modem_model mcm_modem_model_inst (.clk(clk), .slow(slow), .line_up(line_up), .stubborn(stubborn),
		.dtr(dtr), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .dcd(dcd),
		.byte_cnt(byte_cnt), .bang_cnt(bang_cnt), .last_byte(last_byte));

	////////////////////////////////////////////////////////////
	// Clock and cycle ceiling
	initial begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	// Polls status until the string sender is not busy and, if asked, a response stands
	task automatic wait_free(input logic need_resp);
		apb(1'b0, mcm_pkg::REG_STAT, 32'h0, st);
		while (st[4] !== 1'b0 || (need_resp && st[2] !== 1'b1)) // No own limit
			apb(1'b0, mcm_pkg::REG_STAT, 32'h0, st);
	endtask

	// Pulses one host command and checks the gate in the cycle its answer stands
	task automatic host_cmd(input logic [7:0] code, input logic exp);
		host_cmd_valid <= 1'b1;
		host_cmd_code  <= code;
		link_activity  <= 1'b1;
		@(posedge clk);
		host_cmd_valid <= 1'b0;
		link_activity  <= 1'b0;
		@(posedge clk);
		chk(host_cmd_reject, exp, "host command gate");
	endtask

	// Issues one request and leaves the final status in st
	task automatic req(input logic [7:0] cmd, input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] d1);
		logic [31:0] q;
		apb(1'b1, mcm_pkg::REG_REQ0, {a1, a0, cmd, mcm_pkg::SUB_CODE}, q);
		apb(1'b1, mcm_pkg::REG_REQ1, {24'h0, d1}, q);
		apb(1'b1, mcm_pkg::REG_CTRL, 32'h0000_0007, q);
		wait_free(1'b1);
	endtask

	////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		link_activity = 1'b0; host_cmd_valid = 1'b0; host_cmd_code = 8'h00; slow = 1'b1;
		line_up = 1'b0; stubborn = 1'b0; error_cnt = 0; checks_done = 0; cyc = 0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		wait_free(1'b0);
		chk(byte_cnt, 15, "config bytes at reset");
		chk(last_byte, mcm_pkg::CHAR_CR, "config ends in CR");
		chk(bang_cnt, 0, "raw bang");
		apb(1'b0, 8'h20, 32'h0, st);
		chk(st, 32'h0, "unmapped read");
		host_cmd(8'h10, 1'b0);
		req(mcm_pkg::CMD_HANG_TMR, 8'h03, 8'h00, 8'h00);
		chk(st[23:16], 8'h03, "hang timer");
		// Absent directory entries and an index past the range fail
		req(mcm_pkg::CMD_DIAL_DIR, mcm_pkg::MODE_DIAL, 8'h00, 8'h00);
		chk(st[3:0], {2'b01, mcm_pkg::CONN_IDLE}, "dial absent entry");
		req(mcm_pkg::CMD_DIAL_DIR, mcm_pkg::MODE_HUP_DIAL, 8'h07, 8'h00);
		chk(st[3:0], {2'b01, mcm_pkg::CONN_IDLE}, "dial absent entry 7");
		req(mcm_pkg::CMD_DIAL_DIR, mcm_pkg::MODE_DIAL, 8'h08, 8'h00);
		chk(st[3], 1'b0, "dial index 8");
		n0 = byte_cnt;
		req(mcm_pkg::CMD_CFG_MODEM, 8'h00, 8'h00, 8'h00);
		chk(st[3], 1'b1, "configure while idle");
		chk(byte_cnt - n0, 15, "configure bytes");
		// Plain hang-up, then with reconfigure
		req(mcm_pkg::CMD_HANGUP, 8'h00, 8'h00, 8'h00);
		chk(st[3:0], {2'b11, mcm_pkg::CONN_IDLE}, "hang-up idle line");
		n0 = byte_cnt;
		slow <= 1'b0;
		req(mcm_pkg::CMD_HANGUP, 8'h01, 8'h00, 8'h00);
		chk(st[3], 1'b1, "hang-up reconfigure ok");
		chk(int'(byte_cnt - n0 >= 15), 1, "reconfigure sent");
		chk(last_byte, mcm_pkg::CHAR_CR, "reconfigure ends in CR");
		// Carrier survives DTR: hang-up string must end the call
		line_up <= 1'b1; stubborn <= 1'b1;
		repeat (4) @(posedge clk);
		n0 = byte_cnt;
		req(mcm_pkg::CMD_HANGUP, 8'h00, 8'h00, 8'h00);
		chk(st[3:0], {2'b11, mcm_pkg::CONN_IDLE}, "hang-up with carrier");
		chk(int'(byte_cnt - n0 >= 14), 1, "hang-up string sent");
		chk(dcd, 1'b0, "modem left the line");
		line_up <= 1'b0;
		// Deleted hang-up string while carrier stays up
		req(mcm_pkg::CMD_INST_HUP, 8'h00, 8'h00, 8'h00);
		line_up <= 1'b1;
		repeat (4) @(posedge clk);
		// Password locks host commands on the new call until it is given
		req(mcm_pkg::CMD_PASSWORD, 8'h02, 8'h00, 8'h41);
		chk(st[3:0], {2'b11, mcm_pkg::CONN_UP}, "password stored");
		host_cmd(8'h10, 1'b1);
		host_cmd(mcm_pkg::PASSWORD_CMD, 1'b0);
		host_cmd(8'h10, 1'b0);
		req(mcm_pkg::CMD_CFG_MODEM, 8'h00, 8'h00, 8'h00);
		chk(st[5:0], {2'b10, 2'b01, mcm_pkg::CONN_UP}, "configure while connected");
		req(mcm_pkg::CMD_HANGUP, 8'h00, 8'h00, 8'h00);
		chk(st[3:2], 2'b01, "hang-up string missing");
		// Quiet call is ended by the idle timer
		stubborn <= 1'b0;
		repeat (250) @(posedge clk);
		chk(dcd, 1'b0, "idle timer hang-up");
		print_verdict();
	end
endmodule

bind mcm_top mcm_monitor #(.DTR_CYC(DTR_CYC)) mcm_monitor_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .dcd(dcd), .link_activity(link_activity), .host_cmd_valid(host_cmd_valid),
	.host_cmd_code(host_cmd_code), .host_cmd_reject(host_cmd_reject), .dtr(dtr), .tx_ready(tx_ready),
	.tx_data(tx_data), .tx_valid(tx_valid));
`default_nettype wire
